// *** src/rmpu_unit.sv ***
// Design decision made here: strobed register access.
`timescale 1ns/1ns
`default_nettype none
`include "rmpu_defines.svh"

module rmpu_unit
   import rmpu_pkg::*;
(
   // Core side
   rmpu_if.dev  bus
);

   // ****************************************************************
   // Register state
   // ****************************************************************
   logic                ctrl_enable;
   logic                ctrl_handler;
   logic                ctrl_privdef;
   rmpu_region_t        region_select;
   logic [26:0]         base_q   [`RMPU_NUM_REGIONS];
   logic [4:0]          size_q   [`RMPU_NUM_REGIONS];
   logic                en_q     [`RMPU_NUM_REGIONS];
   logic [7:0]          srd_q    [`RMPU_NUM_REGIONS];
   logic                xn_q     [`RMPU_NUM_REGIONS];
   rmpu_ap_t            ap_q     [`RMPU_NUM_REGIONS];
   logic [5:0]          tscb_q   [`RMPU_NUM_REGIONS];
   logic [31:0]         reg_rdata;
   rmpu_region_t        base_target;
   logic                wr_ctrl;
   logic                wr_select;
   logic                wr_base;
   logic                wr_attr;

   assign wr_ctrl   = bus.reg_wr && bus.reg_addr == `RMPU_ADDR_CTRL;
   assign wr_select = bus.reg_wr && bus.reg_addr == `RMPU_ADDR_SELECT;
   assign wr_base   = bus.reg_wr && rmpu_is_base(bus.reg_addr);
   assign wr_attr   = bus.reg_wr && rmpu_is_attr(bus.reg_addr);

   // Valid bit redirects the base write and moves the select
   assign base_target = bus.reg_wdata[`RMPU_BASE_VALID] ? bus.reg_wdata[2:0] : region_select;

   always_ff @(posedge bus.mclk or posedge bus.rst) begin
      if (bus.rst) begin
         ctrl_enable  <= 1'b0;
         ctrl_handler <= 1'b0;
         ctrl_privdef <= 1'b0;
      end else if (wr_ctrl) begin
         ctrl_enable  <= bus.reg_wdata[`RMPU_CTRL_ENABLE];
         ctrl_handler <= bus.reg_wdata[`RMPU_CTRL_HANDLER];
         ctrl_privdef <= bus.reg_wdata[`RMPU_CTRL_PRIVDEF];
      end
   end

   always_ff @(posedge bus.mclk or posedge bus.rst) begin
      if (bus.rst) begin
         region_select <= 3'h0;
      end else if (wr_select) begin
         region_select <= bus.reg_wdata[2:0];
      end else if (wr_base && bus.reg_wdata[`RMPU_BASE_VALID]) begin
         region_select <= bus.reg_wdata[2:0];
      end
   end

   // Aliases decode to the primary pair, so all four reach the selected region
   always_ff @(posedge bus.mclk or posedge bus.rst) begin
      if (bus.rst) begin
         for (int i = 0; i < `RMPU_NUM_REGIONS; i++) begin
            base_q[i] <= 27'h0000000;
         end
      end else if (wr_base) begin
         base_q[base_target] <= bus.reg_wdata[31:`RMPU_BASE_LSB];
      end
   end

   always_ff @(posedge bus.mclk or posedge bus.rst) begin
      if (bus.rst) begin
         for (int i = 0; i < `RMPU_NUM_REGIONS; i++) begin
            size_q[i] <= 5'h00;
            en_q[i]   <= 1'b0;
            srd_q[i]  <= 8'h00;
            xn_q[i]   <= 1'b0;
            ap_q[i]   <= 3'h0;
            tscb_q[i] <= 6'h00;
         end
      end else if (wr_attr) begin
         en_q[region_select]   <= bus.reg_wdata[0];
         size_q[region_select] <= bus.reg_wdata[`RMPU_ATTR_SIZE_LSB +: 5];
         srd_q[region_select]  <= bus.reg_wdata[`RMPU_ATTR_SRD_LSB +: 8];
         xn_q[region_select]   <= bus.reg_wdata[`RMPU_ATTR_XN];
         ap_q[region_select]   <= bus.reg_wdata[`RMPU_ATTR_AP_LSB +: 3];
         tscb_q[region_select] <= bus.reg_wdata[`RMPU_ATTR_B +: 6];
      end
   end

   // ****************************************************************
   // Register read, one cycle after the strobe
   // ****************************************************************
   always_ff @(posedge bus.mclk or posedge bus.rst) begin
      if (bus.rst) begin
         reg_rdata <= 32'h00000000;
      end else if (bus.reg_rd) begin
         if (bus.reg_addr == `RMPU_ADDR_INFO) begin
            reg_rdata <= `RMPU_INFO_VALUE;
         end else if (bus.reg_addr == `RMPU_ADDR_CTRL) begin
            reg_rdata <= {29'h00000000, ctrl_privdef, ctrl_handler, ctrl_enable};
         end else if (bus.reg_addr == `RMPU_ADDR_SELECT) begin
            reg_rdata <= {29'h00000000, region_select};
         end else if (rmpu_is_base(bus.reg_addr)) begin
            reg_rdata <= {base_q[region_select], 2'h0, region_select};
         end else if (rmpu_is_attr(bus.reg_addr)) begin
            reg_rdata <= {3'h0, xn_q[region_select], 1'b0, ap_q[region_select], 2'h0,
                          tscb_q[region_select], srd_q[region_select], 2'h0,
                          size_q[region_select], en_q[region_select]};
         end else begin
            reg_rdata <= 32'h00000000;
         end
      end else begin
         reg_rdata <= 32'h00000000;
      end
   end

   assign bus.reg_rdata = reg_rdata;

   // ****************************************************************
   // Region match, one lane per region
   // ****************************************************************
   function automatic logic ap_allows(input rmpu_ap_t ap, input logic priv, input logic wr);
      case (ap)
         3'b001:  return priv;
         3'b010:  return priv || !wr;
         3'b011:  return 1'b1;
         3'b101:  return priv && !wr;
         3'b110:  return !wr;
         3'b111:  return !wr;
         default: return 1'b0;
      endcase
   endfunction : ap_allows

   logic [`RMPU_NUM_REGIONS-1:0] hit;
   logic [`RMPU_NUM_REGIONS-1:0] allow;

   generate
      for (genvar r = 0; r < `RMPU_NUM_REGIONS; r++) begin : g_region
         logic [31:0] base_full;
         logic        in_range;
         logic [2:0]  sub_idx;
         logic        sub_off;

         assign base_full = {base_q[r], 5'h00};
         // Whole map when size is full, base bits disregarded
         assign in_range = (size_q[r] == `RMPU_SIZE_FULL) ||
                           ((bus.acc_addr >> (size_q[r] + 5'h01)) ==
                            (base_full >> (size_q[r] + 5'h01)));
         assign sub_idx  = 3'((bus.acc_addr >> (size_q[r] - 5'h02)) & 32'h00000007);
         assign sub_off  = (size_q[r] >= `RMPU_SIZE_SUB_MIN) && srd_q[r][sub_idx];
         // Sizes under 32 bytes are unsupported and never match
         assign hit[r]   = en_q[r] && (size_q[r] >= `RMPU_SIZE_MIN) && in_range && !sub_off;
         assign allow[r] = ap_allows(ap_q[r], bus.acc_priv, bus.acc_write) &&
                           !(bus.acc_fetch && xn_q[r]);
      end
   endgenerate

   // ****************************************************************
   // Access decision
   // ****************************************************************
   logic      any_hit;
   logic      win_allow;
   logic      in_scs;
   logic      in_vect;
   logic      prot_on;
   rmpu_chk_e next_chk;

   // Highest numbered region wins an overlap
   always_comb begin
      any_hit   = 1'b0;
      win_allow = 1'b0;
      for (int i = 0; i < `RMPU_NUM_REGIONS; i++) begin
         if (hit[i]) begin
            any_hit   = 1'b1;
            win_allow = allow[i];
         end
      end
   end

   assign in_scs  = (bus.acc_addr & `RMPU_SCS_MASK) == `RMPU_SCS_BASE;
   assign in_vect = (bus.acc_addr & `RMPU_VECT_MASK) == `RMPU_VECT_BASE;
   // Escalated handlers run unchecked unless the handler bit is set
   assign prot_on = ctrl_enable && (!bus.acc_prio_neg || ctrl_handler);

   always_comb begin
      next_chk = RMPU_CHK_IDLE;
      if (bus.acc_valid) begin
         if (in_scs && bus.acc_fetch) begin
            next_chk = RMPU_CHK_FAULT;
         end else if (!prot_on) begin
            next_chk = RMPU_CHK_GRANT;
         end else if (in_scs || in_vect) begin
            next_chk = RMPU_CHK_GRANT;
         end else if (any_hit) begin
            next_chk = win_allow ? RMPU_CHK_GRANT : RMPU_CHK_FAULT;
         end else if (ctrl_privdef && bus.acc_priv) begin
            next_chk = RMPU_CHK_GRANT;
         end else begin
            next_chk = RMPU_CHK_FAULT;
         end
      end
   end

   // ****************************************************************
   // Answer, one cycle after the request
   // ****************************************************************
   rmpu_chk_e chk;
   logic      ordered;

   always_ff @(posedge bus.mclk or posedge bus.rst) begin
      if (bus.rst) begin
         chk <= RMPU_CHK_IDLE;
      end else begin
         chk <= next_chk;
      end
   end

   // Control space is strongly ordered whatever the enable says
   always_ff @(posedge bus.mclk or posedge bus.rst) begin
      if (bus.rst) begin
         ordered <= 1'b0;
      end else begin
         ordered <= bus.acc_valid && in_scs;
      end
   end

   always_comb begin
      case (chk)
         RMPU_CHK_GRANT: begin
            bus.acc_grant = 1'b1;
            bus.acc_fault = 1'b0;
         end
         RMPU_CHK_FAULT: begin
            bus.acc_grant = 1'b0;
            bus.acc_fault = 1'b1;
         end
         default: begin
            bus.acc_grant = 1'b0;
            bus.acc_fault = 1'b0;
         end
      endcase
   end

   assign bus.acc_ordered = ordered;

endmodule : rmpu_unit

`default_nettype wire

// *** src/rmpu_defines.svh ***
// Function
// - Instruction region count always reads zero
// - Data region count reads eight
// - Info bit 0 reads zero: unified map
// - Enabled, no background: region miss faults
// - Background serves privileged misses below regions
// - Background bit ignored while protection disabled
// - Protect-enable clear bypasses checks in escalated handlers
// - Priority -1/-2 handlers unchecked unless protect-enable
// - Disabled unit applies default map to everyone
// - Unprivileged miss faults even with background
// - Control space is always execute-never, ordered
// - Control space data access and vector table always allowed
// - Software enables a region before plain enable
// - Never set protect-enable while protection disabled
// - Region select takes only values 0-7
// - Base write with valid bit updates select
// - Base from upper bits, valid bit 4
// - Software aligns base to region size
// - 4 GB region ignores base, covers all
// - Valid reads zero, region field reads select
// - Region size is two to size+1, min 32B
// - Regions of 256B+ have eight disable subregions
`ifndef RMPU_DEFINES_SVH
`define RMPU_DEFINES_SVH

`define RMPU_ADDR_INFO        32'he000ed90
`define RMPU_ADDR_CTRL        32'he000ed94
`define RMPU_ADDR_SELECT      32'he000ed98
`define RMPU_ADDR_BASE        32'he000ed9c
`define RMPU_ADDR_ATTR        32'he000eda0
`define RMPU_ADDR_BASE_A1     32'he000eda4
`define RMPU_ADDR_ATTR_A1     32'he000eda8
`define RMPU_ADDR_BASE_A2     32'he000edac
`define RMPU_ADDR_ATTR_A2     32'he000edb0
`define RMPU_ADDR_BASE_A3     32'he000edb4
`define RMPU_ADDR_ATTR_A3     32'he000edb8

`define RMPU_INFO_VALUE       32'h00000800
`define RMPU_NUM_REGIONS      8
`define RMPU_CTRL_ENABLE      0
`define RMPU_CTRL_HANDLER     1
`define RMPU_CTRL_PRIVDEF     2
`define RMPU_BASE_VALID       4
`define RMPU_BASE_LSB         5
`define RMPU_ATTR_XN          28
`define RMPU_ATTR_AP_LSB      24
`define RMPU_ATTR_TEX_LSB     19
`define RMPU_ATTR_S           18
`define RMPU_ATTR_C           17
`define RMPU_ATTR_B           16
`define RMPU_ATTR_SRD_LSB     8
`define RMPU_ATTR_SIZE_LSB    1
`define RMPU_SIZE_MIN         5'h04
`define RMPU_SIZE_SUB_MIN     5'h07
`define RMPU_SIZE_FULL        5'h1f
`define RMPU_SCS_BASE         32'he000e000
`define RMPU_SCS_MASK         32'hfffff000
`define RMPU_VECT_BASE        32'h00000000
`define RMPU_VECT_MASK        32'hfffffc00

`endif

// *** src/rmpu_pkg.sv ***
`include "rmpu_defines.svh"

package rmpu_pkg;

   typedef logic [2:0] rmpu_region_t;
   typedef logic [2:0] rmpu_ap_t;

   typedef enum logic [1:0] {
      RMPU_CHK_IDLE  = 2'b00,
      RMPU_CHK_GRANT = 2'b01,
      RMPU_CHK_FAULT = 2'b10
   } rmpu_chk_e;

   function automatic logic rmpu_is_base(input logic [31:0] a);
      return a == `RMPU_ADDR_BASE || a == `RMPU_ADDR_BASE_A1 ||
             a == `RMPU_ADDR_BASE_A2 || a == `RMPU_ADDR_BASE_A3;
   endfunction : rmpu_is_base

   function automatic logic rmpu_is_attr(input logic [31:0] a);
      return a == `RMPU_ADDR_ATTR || a == `RMPU_ADDR_ATTR_A1 ||
             a == `RMPU_ADDR_ATTR_A2 || a == `RMPU_ADDR_ATTR_A3;
   endfunction : rmpu_is_attr

endpackage : rmpu_pkg

// *** src/rmpu_if.sv ***
`timescale 1ns/1ns
`default_nettype none

interface rmpu_if (
   input wire logic mclk,
   input wire logic rst
);
   // Register port
   logic [31:0] reg_addr;
   logic [31:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [31:0] reg_rdata;
   // Access check
   logic        acc_valid;
   logic [31:0] acc_addr;
   logic        acc_write;
   logic        acc_fetch;
   logic        acc_priv;
   logic        acc_prio_neg;
   logic        acc_grant;
   logic        acc_fault;
   logic        acc_ordered;

   modport dev (
      input  mclk, rst, reg_addr, reg_wdata, reg_wr, reg_rd,
      input  acc_valid, acc_addr, acc_write, acc_fetch, acc_priv, acc_prio_neg,
      output reg_rdata, acc_grant, acc_fault, acc_ordered
   );
   modport core (
      input  mclk, rst, reg_rdata, acc_grant, acc_fault, acc_ordered,
      output reg_addr, reg_wdata, reg_wr, reg_rd,
      output acc_valid, acc_addr, acc_write, acc_fetch, acc_priv, acc_prio_neg
   );
endinterface : rmpu_if

`default_nettype wire

// *** src/rmpu_core_end.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "rmpu_defines.svh"

module rmpu_core_end
   import rmpu_pkg::*;
(
   // Link to the protection unit
   rmpu_if.core             bus,
   // Software register port
   input  wire logic [31:0] sw_addr,
   input  wire logic [31:0] sw_wdata,
   input  wire logic        sw_wr,
   input  wire logic        sw_rd,
   output logic      [31:0] sw_rdata,
   output logic             sw_refused,
   // Load, store and fetch requests
   input  wire logic        cpu_valid,
   input  wire logic [31:0] cpu_addr,
   input  wire logic        cpu_write,
   input  wire logic        cpu_fetch,
   input  wire logic        cpu_priv,
   input  wire logic        cpu_prio_neg,
   output logic             cpu_grant,
   output logic             cpu_fault,
   output logic             cpu_ordered
);

   // Shadows of what the unit holds, used only to screen writes
   rmpu_region_t                  sh_select;
   logic [`RMPU_NUM_REGIONS-1:0]  sh_en;
   logic [4:0]                    sh_size [`RMPU_NUM_REGIONS];
   rmpu_region_t                  tgt;
   logic                          bad;
   logic                          refused;

   assign tgt = sw_wdata[`RMPU_BASE_VALID] ? sw_wdata[2:0] : sh_select;

   always_comb begin
      bad = 1'b0;
      if (sw_addr == `RMPU_ADDR_SELECT) begin
         bad = sw_wdata[31:3] != 29'h00000000;
      end else if (sw_addr == `RMPU_ADDR_CTRL) begin
         bad = (sw_wdata[`RMPU_CTRL_HANDLER] && !sw_wdata[`RMPU_CTRL_ENABLE]) ||
               (sw_wdata[`RMPU_CTRL_ENABLE] && !sw_wdata[`RMPU_CTRL_PRIVDEF] &&
                sh_en == '0);
      end else if (rmpu_is_base(sw_addr) && sh_size[tgt] != `RMPU_SIZE_FULL) begin
         // Low five bits carry valid and region, not address, so they stay out of the test
         bad = (({sw_wdata[31:5], 5'h00} >> (sh_size[tgt] + 5'h01)) << (sh_size[tgt] + 5'h01)) !=
               {sw_wdata[31:5], 5'h00};
      end
   end

   assign refused = sw_wr && bad;

   always_ff @(posedge bus.mclk or posedge bus.rst) begin
      if (bus.rst) begin
         sh_select <= 3'h0;
         sh_en     <= '0;
         for (int i = 0; i < `RMPU_NUM_REGIONS; i++) begin
            sh_size[i] <= 5'h00;
         end
      end else if (sw_wr && !bad) begin
         if (sw_addr == `RMPU_ADDR_SELECT || (rmpu_is_base(sw_addr) && sw_wdata[`RMPU_BASE_VALID])) begin
            sh_select <= sw_wdata[2:0];
         end
         // Enable and size shadows feed the enable and alignment screens
         if (rmpu_is_attr(sw_addr)) begin
            sh_en[sh_select]   <= sw_wdata[0];
            sh_size[sh_select] <= sw_wdata[`RMPU_ATTR_SIZE_LSB +: 5];
         end
      end
   end

   always_ff @(posedge bus.mclk or posedge bus.rst) begin
      if (bus.rst) begin
         sw_refused <= 1'b0;
      end else begin
         sw_refused <= refused;
      end
   end

   assign bus.reg_addr     = sw_addr;
   assign bus.reg_wdata    = sw_wdata;
   assign bus.reg_wr       = sw_wr && !bad;
   assign bus.reg_rd       = sw_rd;
   assign sw_rdata         = bus.reg_rdata;
   assign bus.acc_valid    = cpu_valid;
   assign bus.acc_addr     = cpu_addr;
   assign bus.acc_write    = cpu_write;
   assign bus.acc_fetch    = cpu_fetch;
   assign bus.acc_priv     = cpu_priv;
   assign bus.acc_prio_neg = cpu_prio_neg;
   assign cpu_grant        = bus.acc_grant;
   assign cpu_fault        = bus.acc_fault;
   assign cpu_ordered      = bus.acc_ordered;

endmodule : rmpu_core_end

`default_nettype wire

// *** tb/rmpu_properties.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "rmpu_defines.svh"

module rmpu_properties (
   // Clock and reset
   input wire logic        mclk,
   input wire logic        rst,
   // Register port
   input wire logic [31:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   // Access check
   input wire logic        acc_valid,
   input wire logic [31:0] acc_addr,
   input wire logic        acc_fetch,
   input wire logic        acc_prio_neg,
   input wire logic        acc_grant,
   input wire logic        acc_fault,
   input wire logic        acc_ordered
);
   // ********************
   // Helper logic
   // ********************
   logic [2:0] ctrl_q;
   logic [2:0] wr_region;
   logic       in_scs;
   logic       in_vect;
   logic       is_base;
   assign wr_region = reg_wdata[2:0];
   assign in_scs    = (acc_addr & `RMPU_SCS_MASK) == `RMPU_SCS_BASE;
   assign in_vect   = (acc_addr & `RMPU_VECT_MASK) == `RMPU_VECT_BASE;
   assign is_base   = reg_addr inside {`RMPU_ADDR_BASE, `RMPU_ADDR_BASE_A1, `RMPU_ADDR_BASE_A2, `RMPU_ADDR_BASE_A3};
   // Refused writes never reach the unit, so this mirrors the unit's own control bits
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ctrl_q <= 3'h0;
      end else if (reg_wr && reg_addr == `RMPU_ADDR_CTRL) begin
         ctrl_q <= reg_wdata[2:0];
      end
   end

   // ********************
   // Properties
   // ********************
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);

   a_one_answer: assert property (acc_valid |=> acc_grant ^ acc_fault)
      else $error("access not answered by exactly one of grant and fault");
   a_no_stray_answer: assert property (!acc_valid |=> !acc_grant && !acc_fault)
      else $error("answer without a request");
   a_ordered_scs: assert property (acc_valid |=> acc_ordered == $past(in_scs))
      else $error("ordered flag does not match control space");
   a_scs_fetch_fault: assert property (acc_valid && acc_fetch && in_scs |=> acc_fault)
      else $error("fetch from control space not faulted");
   a_scs_vect_open: assert property (acc_valid && (in_vect || (in_scs && !acc_fetch)) |=> acc_grant)
      else $error("control space or vector table access refused");
   a_off_grants: assert property (acc_valid && !in_scs && !ctrl_q[0] |=> acc_grant)
      else $error("access refused while protection off");
   a_handler_bypass: assert property (acc_valid && !in_scs && acc_prio_neg && !ctrl_q[1] |=> acc_grant)
      else $error("escalated handler access checked");
   a_info_value: assert property (reg_rd && reg_addr == `RMPU_ADDR_INFO |=> reg_rdata == 32'h00000800)
      else $error("info register value wrong");
   a_valid_reads_zero: assert property (reg_rd && is_base |=> reg_rdata[4:3] == 2'h0)
      else $error("base register valid bit reads nonzero");
   a_base_selects: assert property (reg_wr && is_base && reg_wdata[4] ##2 reg_rd && reg_addr == `RMPU_ADDR_SELECT
      |=> reg_rdata == {29'h0, $past(wr_region, 3)})
      else $error("valid base write did not update region select");
endmodule : rmpu_properties

`default_nettype wire

// *** tb/tb_region_memory_protection_unit.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "rmpu_defines.svh"

module tb_region_memory_protection_unit
   import rmpu_pkg::*;
;
   // ********************
   // Signals
   // ********************
   logic        mclk         = 1'b0;
   logic        rst          = 1'b1;
   logic [31:0] sw_addr      = 32'h0;
   logic [31:0] sw_wdata     = 32'h0;
   logic        sw_wr        = 1'b0;
   logic        sw_rd        = 1'b0;
   logic        cpu_valid    = 1'b0;
   logic [31:0] cpu_addr     = 32'h0;
   logic        cpu_write    = 1'b0;
   logic        cpu_fetch    = 1'b0;
   logic        cpu_priv     = 1'b0;
   logic        cpu_prio_neg = 1'b0;
   logic [31:0] sw_rdata;
   logic        sw_refused;
   logic        cpu_grant;
   logic        cpu_fault;
   logic        cpu_ordered;
   logic        rd_d         = 1'b0;
   logic        wr_d         = 1'b0;
   logic        acc_d        = 1'b0;
   logic [31:0] rd_q[$];
   logic        ref_q[$];
   logic [2:0]  acc_q[$];
   logic [5:0]  off;
   int          n_errors     = 0;
   int          n_tests      = 0;
   int          cyc          = 0;
   integer      seed         = 32'h3d1c;

   initial begin
      forever #25 mclk = ~mclk;
   end

   rmpu_if i_rmpu_if (.mclk(mclk), .rst(rst));
   rmpu_unit i_rmpu_unit (.bus(i_rmpu_if));
   rmpu_core_end i_rmpu_core_end (
      .bus(i_rmpu_if), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
      .sw_rdata(sw_rdata), .sw_refused(sw_refused), .cpu_valid(cpu_valid), .cpu_addr(cpu_addr),
      .cpu_write(cpu_write), .cpu_fetch(cpu_fetch), .cpu_priv(cpu_priv), .cpu_prio_neg(cpu_prio_neg),
      .cpu_grant(cpu_grant), .cpu_fault(cpu_fault), .cpu_ordered(cpu_ordered));
   rmpu_properties i_rmpu_properties (
      .mclk(i_rmpu_if.mclk), .rst(i_rmpu_if.rst), .reg_addr(i_rmpu_if.reg_addr),
      .reg_wdata(i_rmpu_if.reg_wdata), .reg_wr(i_rmpu_if.reg_wr), .reg_rd(i_rmpu_if.reg_rd),
      .reg_rdata(i_rmpu_if.reg_rdata), .acc_valid(i_rmpu_if.acc_valid), .acc_addr(i_rmpu_if.acc_addr),
      .acc_fetch(i_rmpu_if.acc_fetch), .acc_prio_neg(i_rmpu_if.acc_prio_neg),
      .acc_grant(i_rmpu_if.acc_grant), .acc_fault(i_rmpu_if.acc_fault), .acc_ordered(i_rmpu_if.acc_ordered));

   // ********************
   // Checking
   // ********************
   task automatic fail(input string m);
      n_errors++;
      $display("[FAIL] %0t %s", $time, m);
   endtask : fail

   // An empty queue yields unknowns, so an unexpected result matches only if it is all unknowns itself
   task automatic chk_rd(input logic [31:0] got);
      n_tests++;
      if (got !== (rd_q.size() ? rd_q.pop_front() : 32'hx)) fail("read data");
   endtask : chk_rd

   task automatic chk_ref(input logic got);
      n_tests++;
      if (got !== (ref_q.size() ? ref_q.pop_front() : 1'bx)) fail("refused flag");
   endtask : chk_ref

   task automatic chk_acc(input logic [2:0] got);
      n_tests++;
      if (got !== (acc_q.size() ? acc_q.pop_front() : 3'hx)) fail("access answer");
   endtask : chk_acc

   always @(posedge mclk) begin
      if (rd_d) chk_rd(sw_rdata);
      if (wr_d) chk_ref(sw_refused);
      if (acc_d || cpu_grant || cpu_fault) chk_acc({cpu_grant, cpu_fault, cpu_ordered});
      rd_d = sw_rd;
      wr_d = sw_wr;
      acc_d = cpu_valid;
   end

   task automatic final_report();
      if (rd_q.size() + ref_q.size() + acc_q.size() != 0) fail("results missing");
      $display("compares %0d, mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : final_report

   always @(posedge mclk) begin
      cyc++;
      if (cyc == 2000) begin
         fail("timeout");
         final_report();
      end
   end

   // ********************
   // Drivers
   // ********************
   task automatic wr(input logic [7:0] o, input logic [31:0] d, input logic r);
      @(posedge mclk);
      sw_addr <= {24'he000ed, o};
      sw_wdata <= d;
      sw_wr <= 1'b1;
      ref_q.push_back(r);
      @(posedge mclk);
      sw_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] o, input logic [31:0] e);
      @(posedge mclk);
      sw_addr <= {24'he000ed, o};
      sw_rd <= 1'b1;
      rd_q.push_back(e);
      @(posedge mclk);
      sw_rd <= 1'b0;
   endtask : rd

   task automatic acc(input logic [31:0] a, input logic w, f, p, n, g);
      @(posedge mclk);
      cpu_addr <= a;
      cpu_write <= w;
      cpu_fetch <= f;
      cpu_priv <= p;
      cpu_prio_neg <= n;
      cpu_valid <= 1'b1;
      acc_q.push_back({g, !g, a[31:12] == 20'he000e});
      @(posedge mclk);
      cpu_valid <= 1'b0;
   endtask : acc

   // ********************
   // Scenarios
   // ********************
   initial begin
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      for (int i = 0; i < 12; i++) rd(8'h90 + 8'(4 * i), i == 0 ? 32'h00000800 : 32'h0);
      $display("reset values done");
      wr(8'h94, 32'h1, 1'b1);
      wr(8'h94, 32'h2, 1'b1);
      wr(8'h98, 32'h8, 1'b1);
      rd(8'h94, 32'h0);
      wr(8'h94, 32'h4, 1'b0);
      acc(32'h30000000, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
      acc(32'he000e010, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
      $display("disabled unit done");
      wr(8'h98, 32'h2, 1'b0);
      wr(8'ha0, 32'h03000213, 1'b0);
      wr(8'h9c, 32'h20000000, 1'b0);
      wr(8'hac, 32'h20000415, 1'b0);
      rd(8'h98, 32'h5);
      rd(8'ha4, 32'h20000405);
      wr(8'hb8, 32'h11000013, 1'b0);
      rd(8'ha0, 32'h11000013);
      wr(8'h9c, 32'h20000600, 1'b1);
      wr(8'h9c, 32'h50000013, 1'b0);
      wr(8'ha0, 32'h03000009, 1'b0);
      $display("region setup done");
      wr(8'h94, 32'h1, 1'b0);
      acc(32'h20000010, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
      acc(32'h20000090, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
      acc(32'h20000410, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      acc(32'h20000410, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
      acc(32'h30000000, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
      acc(32'h30000000, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
      acc(32'he000ed00, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
      acc(32'h00000100, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
      acc(32'h5000001f, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
      acc(32'h50000020, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      wr(8'h94, 32'h7, 1'b0);
      acc(32'h30000000, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
      acc(32'h30000000, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      acc(32'h30000000, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
      acc(32'h20000410, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
      acc(32'h20000090, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
      for (int i = 0; i < 16; i++) begin
         off = 6'($random(seed));
         acc(32'h50000000 + 32'(off), off[0], 1'b0, 1'b0, 1'b0, off < 6'd32);
      end
      $display("enabled checks done");
      wr(8'h9c, 32'h40000017, 1'b0);
      wr(8'ha0, 32'h0600003f, 1'b0);
      wr(8'h9c, 32'h12345660, 1'b0);
      acc(32'h30000000, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
      acc(32'h20000010, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
      wr(8'ha8, 32'h0500003f, 1'b0);
      acc(32'h30000000, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
      acc(32'h30000000, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
      acc(32'h30000000, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      wr(8'hb0, 32'h0200003f, 1'b0);
      acc(32'h30000000, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
      acc(32'h30000000, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
      acc(32'h30000000, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
      $display("full map region done");
      @(posedge mclk);
      rst <= 1'b1;
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      rd(8'h94, 32'h0);
      rd(8'h98, 32'h0);
      $display("second reset done");
      repeat (3) @(posedge mclk);
      final_report();
   end
endmodule : tb_region_memory_protection_unit

`default_nettype wire
